/* include/mis_params.svh */
// Constants for the module indication signals block
`ifndef MIS_PARAMS_SVH
`define MIS_PARAMS_SVH

// ==========================================================
// Clock period in nanoseconds, other times in microseconds
// ==========================================================
`define MIS_CLK_NS      10
`define MIS_T_ADV_US    10500
`define MIS_T_DLY_US    4000
`define MIS_T_RING_US   1000
`define MIS_T_SEC_US    1000000
`define MIS_T_NAV_PW_US 100

// Least time to cycles, rounded up
`define MIS_US2CYC(us) ((((us) * 1000) + `MIS_CLK_NS - 1) / `MIS_CLK_NS)

`define MIS_ADV_CYC    `MIS_US2CYC(`MIS_T_ADV_US)
`define MIS_DLY_CYC    `MIS_US2CYC(`MIS_T_DLY_US)
`define MIS_RING_CYC   `MIS_US2CYC(`MIS_T_RING_US)
`define MIS_SEC_CYC    `MIS_US2CYC(`MIS_T_SEC_US)
`define MIS_NAV_PW_CYC `MIS_US2CYC(`MIS_T_NAV_PW_US)

// ==========================================================
// Field layout and reset values
// ==========================================================
`define MIS_PIN_NUM      4
`define MIS_FOURTH_PIN   3
`define MIS_RING_PEND_MAX 4'hf
`define MIS_BAND_EN_RST  1'h0
`define MIS_ANT_LVL_RST  4'h0

`endif

/* include/mis_pkg.sv */
// Types shared by the module indication signals block
package mis_pkg;

  // ========================================================
  // Counters and commands
  // ========================================================
  typedef logic [31:0] mis_cnt_t;

  // Antenna select command: band plus one level per pin
  typedef struct packed {
    logic [7:0] band;
    logic [3:0] level;
    logic       has_fourth;
  } mis_antsel_s;

  // Per pin function: antenna control or general purpose
  typedef struct packed {
    logic [3:0] gpio_mode;
    logic [3:0] gpio_dir;
    logic [3:0] gpio_val;
  } mis_pincfg_s;

  // ========================================================
  // State machines
  // ========================================================
  typedef enum logic [1:0] {MIS_TX_IDLE, MIS_TX_ADV, MIS_TX_ON, MIS_TX_HOLD} mis_tx_e;
  typedef enum logic [1:0] {MIS_RI_IDLE, MIS_RI_HIGH, MIS_RI_GAP} mis_ri_e;

endpackage

/* logic/mis_txon_timer.sv */
// Transmit activity indicator with advance and trailing delay
`include "mis_params.svh"

module mis_txon_timer #(
  parameter mis_pkg::mis_cnt_t ADV_CYC = mis_pkg::mis_cnt_t'(`MIS_ADV_CYC),
  parameter mis_pkg::mis_cnt_t DLY_CYC = mis_pkg::mis_cnt_t'(`MIS_DLY_CYC)
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Request side
  input  wire logic tx_req_i,
  input  wire logic allow_i,
  // Indicator and permission
  output logic      tx_on_o,
  output logic      tx_grant_o
);

  mis_pkg::mis_tx_e  state_r;  // Sequencer state
  mis_pkg::mis_cnt_t cnt_r;    // Advance or delay countdown
  logic              go;       // Wanted and allowed

  assign go = tx_req_i && allow_i;

  // ========================================================
  // Sequencer: indicator leads the grant and trails it
  // ========================================================
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_r    <= mis_pkg::MIS_TX_IDLE;
      cnt_r      <= '0;
      tx_on_o    <= 1'b0;
      tx_grant_o <= 1'b0;
    end else begin
      case (state_r)
        mis_pkg::MIS_TX_IDLE: begin
          if (go) begin
            state_r <= mis_pkg::MIS_TX_ADV;
            cnt_r   <= mis_pkg::mis_cnt_t'(ADV_CYC - 1);
            tx_on_o <= 1'b1;
          end
        end
        mis_pkg::MIS_TX_ADV: begin
          // Cancelled before the burst: nothing was sent
          if (!go) begin
            state_r <= mis_pkg::MIS_TX_IDLE;
            tx_on_o <= 1'b0;
          end else if (cnt_r == '0) begin
            state_r    <= mis_pkg::MIS_TX_ON;
            tx_grant_o <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        mis_pkg::MIS_TX_ON: begin
          if (!go) begin
            state_r    <= mis_pkg::MIS_TX_HOLD;
            tx_grant_o <= 1'b0;
            cnt_r      <= mis_pkg::mis_cnt_t'(DLY_CYC - 1);
          end
        end
        mis_pkg::MIS_TX_HOLD: begin
          // New burst inside the tail gets a full advance again
          if (go) begin
            state_r <= mis_pkg::MIS_TX_ADV;
            cnt_r   <= mis_pkg::mis_cnt_t'(ADV_CYC - 1);
          end else if (cnt_r == '0) begin
            state_r <= mis_pkg::MIS_TX_IDLE;
            tx_on_o <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: state_r <= mis_pkg::MIS_TX_IDLE;
      endcase
    end
  end

endmodule // mis_txon_timer

/* logic/mis_nav_sync.sv */
// Once per second navigation sync pulse with holdover
`include "mis_params.svh"

module mis_nav_sync #(
  parameter mis_pkg::mis_cnt_t SEC_CYC = mis_pkg::mis_cnt_t'(`MIS_SEC_CYC),
  parameter mis_pkg::mis_cnt_t PW_CYC  = mis_pkg::mis_cnt_t'(`MIS_NAV_PW_CYC)
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Time source
  input  wire logic sec_edge_i,
  input  wire logic fix_valid_i,
  input  wire logic unc_high_i,
  // Pulse out
  output logic      pulse_o
);

  mis_pkg::mis_cnt_t sec_cnt_r;  // Local second, free running
  mis_pkg::mis_cnt_t pw_cnt_r;   // Pulse width countdown
  logic              synced_r;   // Local second has been aligned
  logic              align;      // Boundary seen under a fix
  logic              fire;       // Start a pulse now

  assign align = fix_valid_i && sec_edge_i;
  // Holdover only once aligned and while time is still trusted
  assign fire  = align || (!fix_valid_i && !unc_high_i && synced_r
                           && sec_cnt_r == '0);

  // ========================================================
  // Local second counter, pulled onto the boundary
  // ========================================================
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sec_cnt_r <= '0;
      synced_r  <= 1'b0;
    end else begin
      if (align || sec_cnt_r == '0) begin
        sec_cnt_r <= mis_pkg::mis_cnt_t'(SEC_CYC - 1);
      end else begin
        sec_cnt_r <= sec_cnt_r - 1'b1;
      end
      if (align) begin
        synced_r <= 1'b1;
      end else if (unc_high_i && !fix_valid_i) begin
        synced_r <= 1'b0;
      end
    end
  end

  // ========================================================
  // Pulse generator, one pulse per second
  // ========================================================
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pulse_o  <= 1'b0;
      pw_cnt_r <= '0;
    end else if (fire) begin
      pulse_o  <= 1'b1;
      pw_cnt_r <= mis_pkg::mis_cnt_t'(PW_CYC - 1);
    end else if (pulse_o) begin
      if (pw_cnt_r == '0) begin
        pulse_o <= 1'b0;
      end else begin
        pw_cnt_r <= pw_cnt_r - 1'b1;
      end
    end
  end

endmodule // mis_nav_sync

/* logic/mis_indication_top.sv */
// Discrete indication and control lines between module and host
// Functional notes
// - Transmit indicator high during transmission
// - LED line sinks only, released otherwise
// - Host wake goes high on wake events
// - Ring indicator pulses per notifiable event
// - Power removal flag only when safe
// - One nav pulse every second
// - Nav pulse aligned to boundary under fix
// - Holdover pulses while uncertainty stays low
// - High uncertainty without a fix stops the nav pulses
// - Radio disabled: no transmit, no receive
// - Radio disable input pulled up internally
// - Four optional antenna switch outputs
// - Band select enable survives restarts
// - Band levels drive pins zero to three
// - Each antenna pin may become GPIO
`include "mis_params.svh"

module mis_indication_top #(
  parameter mis_pkg::mis_cnt_t ADV_CYC    = mis_pkg::mis_cnt_t'(`MIS_ADV_CYC),
  parameter mis_pkg::mis_cnt_t DLY_CYC    = mis_pkg::mis_cnt_t'(`MIS_DLY_CYC),
  parameter mis_pkg::mis_cnt_t RING_CYC   = mis_pkg::mis_cnt_t'(`MIS_RING_CYC),
  parameter mis_pkg::mis_cnt_t SEC_CYC    = mis_pkg::mis_cnt_t'(`MIS_SEC_CYC),
  parameter mis_pkg::mis_cnt_t NAV_PW_CYC = mis_pkg::mis_cnt_t'(`MIS_NAV_PW_CYC)
) (
  // Clock, restart reset and power-on reset
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 por_n_i,
  // Transmit activity
  input  wire logic                 tx_req_i,
  output logic                      tx_on_o,
  output logic                      tx_grant_o,
  // Radio disable and receive path
  input  wire logic                 radio_disable_n_i,
  output logic                      radio_disable_pu_o,
  input  wire logic                 rx_req_i,
  output logic                      rx_enable_o,
  // Status LED, open drain
  input  wire logic                 led_on_i,
  output logic                      link_led_drive_n_o,
  output logic                      link_led_drive_n_oe_o,
  // Host wake
  input  wire logic                 wake_event_i,
  input  wire logic                 host_wake_clr_i,
  output logic                      host_wake_out_o,
  // Ring indicate
  input  wire logic                 ring_event_i,
  output logic                      ring_indicate_out_o,
  // Safe power removal
  input  wire logic                 shutdown_done_i,
  output logic                      power_removal_ok_o,
  // Navigation second
  input  wire logic                 nav_sec_edge_i,
  input  wire logic                 nav_fix_valid_i,
  input  wire logic                 nav_unc_high_i,
  output logic                      nav_second_pulse_o,
  // Band selection and antenna select command
  input  wire logic                 band_sel_wr_i,
  input  wire logic                 band_sel_val_i,
  output logic                      band_select_enable_o,
  input  wire logic                 antsel_valid_i,
  input  wire mis_pkg::mis_antsel_s antenna_select_command_i,
  output logic [7:0]                antsel_band_o,
  // Antenna switch pins and their function
  input  wire mis_pkg::mis_pincfg_s pin_function_config_i,
  input  wire logic [3:0]           antenna_switch_ctrl_i,
  output logic [3:0]                antenna_switch_ctrl_o,
  output logic [3:0]                antenna_switch_ctrl_oe_o,
  output logic [3:0]                ant_gpio_in_o
);

  // ========================================================
  // Helpers
  // ========================================================
  // Reload value of a down counter that must last n cycles
  function automatic mis_pkg::mis_cnt_t cnt_load(input mis_pkg::mis_cnt_t n);
    cnt_load = mis_pkg::mis_cnt_t'(n - 1);
  endfunction

  // ========================================================
  // Radio disable
  // ========================================================
  logic radio_en_r;  // Registered disable pin, high means radio on

  // Pull-up kept on so an open pin leaves the radio running;
  // the host never drives high, so no contention arises
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      radio_en_r         <= 1'b1;
      radio_disable_pu_o <= 1'b1;
    end else begin
      radio_en_r         <= radio_disable_n_i;
      radio_disable_pu_o <= 1'b1;
    end
  end

  // Receive path closed while disabled
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rx_enable_o <= 1'b0;
    end else begin
      rx_enable_o <= rx_req_i && radio_en_r;
    end
  end

  // ========================================================
  // Transmit activity indicator
  // ========================================================
  // Grant withheld while disabled, so no burst can start
  mis_txon_timer #(
    .ADV_CYC    (ADV_CYC),
    .DLY_CYC    (DLY_CYC)
  ) u_txon (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .tx_req_i   (tx_req_i),
    .allow_i    (radio_en_r),
    .tx_on_o    (tx_on_o),
    .tx_grant_o (tx_grant_o)
  );

  // ========================================================
  // Status LED, open drain
  // ========================================================
  // Only ever sinks; data bit is fixed low, enable lights it
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      link_led_drive_n_o    <= 1'b0;
      link_led_drive_n_oe_o <= 1'b0;
    end else begin
      link_led_drive_n_o    <= 1'b0;
      link_led_drive_n_oe_o <= led_on_i;
    end
  end

  // ========================================================
  // Host wake
  // ========================================================
  // Held until the host clears it; a new event wins the clear
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      host_wake_out_o <= 1'b0;
    end else if (wake_event_i) begin
      host_wake_out_o <= 1'b1;
    end else if (host_wake_clr_i) begin
      host_wake_out_o <= 1'b0;
    end
  end

  // ========================================================
  // Ring indicate
  // ========================================================
  mis_pkg::mis_ri_e  ri_state_r;  // High phase, then equal gap
  mis_pkg::mis_cnt_t ri_cnt_r;    // Phase countdown
  logic [3:0]        ri_pend_r;   // Events not yet signalled
  logic              ri_take;     // One pending event consumed

  assign ri_take = (ri_state_r == mis_pkg::MIS_RI_IDLE) && (ri_pend_r != 4'h0);

  // Pending count: events arriving during a pulse are queued, an
  // arrival in the consuming cycle still counts; saturates at 15
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ri_pend_r <= 4'h0;
    end else if (ring_event_i && !ri_take) begin
      if (ri_pend_r != `MIS_RING_PEND_MAX) begin
        ri_pend_r <= ri_pend_r + 4'h1;
      end
    end else if (!ring_event_i && ri_take) begin
      ri_pend_r <= ri_pend_r - 4'h1;
    end
  end

  // Pulse sequencer; the gap keeps back to back pulses distinct
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ri_state_r          <= mis_pkg::MIS_RI_IDLE;
      ri_cnt_r            <= '0;
      ring_indicate_out_o <= 1'b0;
    end else begin
      case (ri_state_r)
        mis_pkg::MIS_RI_IDLE: begin
          if (ri_take) begin
            ri_state_r          <= mis_pkg::MIS_RI_HIGH;
            ri_cnt_r            <= cnt_load(RING_CYC);
            ring_indicate_out_o <= 1'b1;
          end
        end
        mis_pkg::MIS_RI_HIGH: begin
          if (ri_cnt_r == '0) begin
            ri_state_r          <= mis_pkg::MIS_RI_GAP;
            ri_cnt_r            <= cnt_load(RING_CYC);
            ring_indicate_out_o <= 1'b0;
          end else begin
            ri_cnt_r <= ri_cnt_r - 1'b1;
          end
        end
        mis_pkg::MIS_RI_GAP: begin
          if (ri_cnt_r == '0) begin
            ri_state_r <= mis_pkg::MIS_RI_IDLE;
          end else begin
            ri_cnt_r <= ri_cnt_r - 1'b1;
          end
        end
        default: ri_state_r <= mis_pkg::MIS_RI_IDLE;
      endcase
    end
  end

  // ========================================================
  // Safe power removal
  // ========================================================
  // Claimed only if the transmitter was neither lit nor granted in the previous cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      power_removal_ok_o <= 1'b0;
    end else begin
      power_removal_ok_o <= shutdown_done_i && !tx_on_o && !tx_grant_o;
    end
  end

  // ========================================================
  // Navigation second pulse
  // ========================================================
  mis_nav_sync #(
    .SEC_CYC     (SEC_CYC),
    .PW_CYC      (NAV_PW_CYC)
  ) u_nav (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .sec_edge_i  (nav_sec_edge_i),
    .fix_valid_i (nav_fix_valid_i),
    .unc_high_i  (nav_unc_high_i),
    .pulse_o     (nav_second_pulse_o)
  );

  // ========================================================
  // Band selection enable
  // ========================================================
  // Reset only by power-on, so a restart keeps the setting
  always_ff @(posedge clk_i) begin
    if (!por_n_i) begin
      band_select_enable_o <= `MIS_BAND_EN_RST;
    end else if (band_sel_wr_i) begin
      band_select_enable_o <= band_sel_val_i;
    end
  end

  // ========================================================
  // Antenna select levels
  // ========================================================
  logic [3:0] ant_lvl_r;  // Levels for pins zero to three

  // Ignored unless band selection is enabled; the fourth level is
  // optional and keeps its old value when left out
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ant_lvl_r     <= `MIS_ANT_LVL_RST;
      antsel_band_o <= 8'h00;
    end else if (antsel_valid_i && band_select_enable_o) begin
      antsel_band_o  <= antenna_select_command_i.band;
      ant_lvl_r[2:0] <= antenna_select_command_i.level[2:0];
      if (antenna_select_command_i.has_fourth) begin
        ant_lvl_r[`MIS_FOURTH_PIN] <= antenna_select_command_i.level[`MIS_FOURTH_PIN];
      end
    end
  end

  // ========================================================
  // Antenna pins and general purpose use
  // ========================================================
  // Antenna mode drives the level; GPIO mode follows direction bit
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      antenna_switch_ctrl_o    <= 4'h0;
      antenna_switch_ctrl_oe_o <= 4'h0;
      ant_gpio_in_o            <= 4'h0;
    end else begin
      for (int i = 0; i < `MIS_PIN_NUM; i++) begin
        if (pin_function_config_i.gpio_mode[i]) begin
          antenna_switch_ctrl_o[i]    <= pin_function_config_i.gpio_val[i];
          antenna_switch_ctrl_oe_o[i] <= pin_function_config_i.gpio_dir[i];
        end else begin
          antenna_switch_ctrl_o[i]    <= ant_lvl_r[i];
          antenna_switch_ctrl_oe_o[i] <= 1'b1;
        end
      end
      // Input value visible only for pins in GPIO mode
      ant_gpio_in_o <= antenna_switch_ctrl_i & pin_function_config_i.gpio_mode;
    end
  end

  // ========================================================
  // Checks
  // ========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_grant_under_on: assert property (tx_grant_o |-> tx_on_o)
    else $error("grant without transmit indicator");
  a_tail_after_burst: assert property ($fell(tx_grant_o) |-> tx_on_o)
    else $error("indicator dropped with the burst");
  a_disable_blocks: assert property (!radio_en_r |=> !tx_grant_o && !rx_enable_o)
    else $error("radio active while disabled");
  a_led_sinks_only: assert property (led_on_i |=> link_led_drive_n_oe_o && !link_led_drive_n_o)
    else $error("LED not sunk on request");
  a_wake_on_event: assert property (wake_event_i |=> host_wake_out_o)
    else $error("wake event not shown");
  a_ring_starts: assert property (ri_take |=> ring_indicate_out_o ##1 ring_indicate_out_o || RING_CYC == 1)
    else $error("ring pulse missing");
  a_power_safe: assert property (power_removal_ok_o |-> $past(shutdown_done_i) && !$past(tx_on_o))
    else $error("power removal flagged while unsafe");
  a_nav_aligned: assert property (nav_fix_valid_i && nav_sec_edge_i |=> nav_second_pulse_o)
    else $error("nav pulse not aligned");
  a_nav_stops: assert property ($rose(nav_second_pulse_o) |-> $past(nav_fix_valid_i) || !$past(nav_unc_high_i))
    else $error("nav pulse under high uncertainty");
  a_band_kept: assert property (!band_sel_wr_i && por_n_i |=> $stable(band_select_enable_o))
    else $error("band enable changed unasked");
  a_antsel_gated: assert property (!band_select_enable_o |=> $stable(ant_lvl_r))
    else $error("levels changed with band select off");
  a_gpio_mode: assert property (pin_function_config_i.gpio_mode[0] |=> antenna_switch_ctrl_oe_o[0] == $past(pin_function_config_i.gpio_dir[0]))
    else $error("GPIO direction not followed");

  c_burst: cover property ($rose(tx_grant_o) ##[1:20] $fell(tx_grant_o));
  c_ring_queue: cover property (ring_event_i && ring_indicate_out_o);
  c_holdover: cover property (!nav_fix_valid_i && $rose(nav_second_pulse_o));

endmodule // mis_indication_top

/* sim/mis_host_model.sv */
// Host side model of the radio disable line, open drain with device pull-up
module mis_host_model (
  // Clock and host control
  input  wire logic clk_i,
  input  wire logic pull_low_i,
  input  wire logic pu_i,
  // Resolved pin level
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================
  // Floating net stand-in
  // ========================================================
  logic flip_r = 1'b0;  // Toggles so an undriven pin never looks settled
  always @(posedge clk_i) flip_r <= !flip_r;
  // Host only sinks; a released line rides on the pull-up
  assign pin_o = pull_low_i ? 1'b0 : (pu_i ? 1'b1 : flip_r);
endmodule // mis_host_model

/* sim/module_indication_signals_tb.sv */
// Self-checking bench for the module indication signals block
module module_indication_signals_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================
  // Signals, named as the ports
  // ========================================================
  localparam int ADV = 20, DLY = 8, RNG = 4, SEC = 100;
  logic clk_i, resetn_i, por_n_i, tx_req_i, rx_req_i, led_on_i, wake_event_i, host_wake_clr_i;
  logic ring_event_i, shutdown_done_i, nav_sec_edge_i, nav_fix_valid_i, nav_unc_high_i;
  logic band_sel_wr_i, band_sel_val_i, antsel_valid_i, dis_low, radio_disable_n_i;
  logic tx_on_o, tx_grant_o, radio_disable_pu_o, rx_enable_o, link_led_drive_n_o;
  logic link_led_drive_n_oe_o, host_wake_out_o, ring_indicate_out_o, power_removal_ok_o;
  logic nav_second_pulse_o, band_select_enable_o, ri_q, nv_q;
  logic [7:0] antsel_band_o;
  logic [3:0] antenna_switch_ctrl_i, antenna_switch_ctrl_o, antenna_switch_ctrl_oe_o;
  logic [3:0] ant_gpio_in_o, lvl;
  mis_pkg::mis_antsel_s antenna_select_command_i, cmd;
  mis_pkg::mis_pincfg_s pin_function_config_i, cfg;
  int error_cnt = 0, n_tests = 0, n_ri, n_nv, cyc_n = 0;

  mis_indication_top #(.ADV_CYC(ADV), .DLY_CYC(DLY), .RING_CYC(RNG), .SEC_CYC(SEC),
    .NAV_PW_CYC(3)) dut (.clk_i, .resetn_i, .por_n_i, .tx_req_i, .tx_on_o, .tx_grant_o,
    .radio_disable_n_i, .radio_disable_pu_o, .rx_req_i, .rx_enable_o, .led_on_i,
    .link_led_drive_n_o, .link_led_drive_n_oe_o, .wake_event_i, .host_wake_clr_i,
    .host_wake_out_o, .ring_event_i, .ring_indicate_out_o, .shutdown_done_i,
    .power_removal_ok_o, .nav_sec_edge_i, .nav_fix_valid_i, .nav_unc_high_i,
    .nav_second_pulse_o, .band_sel_wr_i, .band_sel_val_i, .band_select_enable_o,
    .antsel_valid_i, .antenna_select_command_i, .antsel_band_o, .pin_function_config_i,
    .antenna_switch_ctrl_i, .antenna_switch_ctrl_o, .antenna_switch_ctrl_oe_o, .ant_gpio_in_o);
  mis_host_model host (.clk_i, .pull_low_i(dis_low), .pu_i(radio_disable_pu_o),
    .pin_o(radio_disable_n_i));

  // ========================================================
  // Clock, pulse counters and hang guard
  // ========================================================
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = !clk_i;
  end
  always @(posedge clk_i) begin
    ri_q <= ring_indicate_out_o;
    nv_q <= nav_second_pulse_o;
    if (ring_indicate_out_o === 1'b1 && ri_q !== 1'b1) n_ri++;
    if (nav_second_pulse_o === 1'b1 && nv_q !== 1'b1) n_nv++;
    if (++cyc_n == 3000) begin  // Whole run needs well under this
      error_cnt++;
      print_verdict();
    end
  end

  // ========================================================
  // Helpers
  // ========================================================
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pin in GPIO mode shows its GPIO bit, otherwise the antenna bit
  function automatic logic [7:0] pin_exp(input logic [3:0] m, g, a);
    return {4'h0, (m & g) | (~m & a)};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ========================================================
  // Main sequence
  // ========================================================
  initial begin
    {resetn_i, por_n_i, tx_req_i, led_on_i, wake_event_i, host_wake_clr_i, ring_event_i} = '0;
    {nav_sec_edge_i, nav_fix_valid_i, nav_unc_high_i, band_sel_wr_i, band_sel_val_i} = '0;
    {antsel_valid_i, dis_low, antenna_switch_ctrl_i, lvl} = '0;
    {antenna_select_command_i, pin_function_config_i} = '0;
    {rx_req_i, shutdown_done_i} = 2'h3;
    void'($urandom(13));
    cyc(20);
    resetn_i <= 1'b1;
    por_n_i <= 1'b1;
    // Burst: lead, grant, trail, then power removal allowed
    cyc(1); tx_req_i <= 1'b1;
    cyc(2); #1 chk(tx_on_o, 1);
    cyc(ADV - 2); #1 chk(tx_grant_o, 0);
    cyc(1); #1 chk(tx_grant_o, 1);
    chk(power_removal_ok_o, 0);
    cyc(1); tx_req_i <= 1'b0;
    cyc(2); #1 chk({tx_grant_o, tx_on_o}, 8'h1);
    cyc(DLY - 2); #1 chk(tx_on_o, 1);
    cyc(1); #1 chk(tx_on_o, 0);
    cyc(2); #1 chk(power_removal_ok_o, 1);
    $display("test burst done");
    // Host pulls disable low: no receive, no transmit start
    cyc(1); dis_low <= 1'b1;
    tx_req_i <= 1'b1;
    cyc(6); #1 chk({rx_enable_o, tx_on_o}, 8'h0);
    cyc(1); dis_low <= 1'b0;
    tx_req_i <= 1'b0;
    cyc(4); #1 chk(rx_enable_o, 1);
    chk(radio_disable_pu_o, 1);
    // Status LED sinks only, random requests
    for (int i = 0; i < 6; i++) begin
      cyc(1); led_on_i <= 1'($urandom);
      cyc(2); #1 chk({link_led_drive_n_oe_o, link_led_drive_n_o}, {led_on_i, 1'b0});
    end
    // Host wake set and clear
    cyc(1); wake_event_i <= 1'b1;
    cyc(1); wake_event_i <= 1'b0;
    cyc(1); #1 chk(host_wake_out_o, 1);
    cyc(1); host_wake_clr_i <= 1'b1;
    cyc(1); host_wake_clr_i <= 1'b0;
    cyc(1); #1 chk(host_wake_out_o, 0);
    // Two back to back ring events give two pulses
    n_ri = 0;
    cyc(1); ring_event_i <= 1'b1;
    cyc(2); ring_event_i <= 1'b0;
    cyc(1); #1 chk(ring_indicate_out_o, 1);
    cyc(5 * RNG); #1 chk(8'(n_ri), 2);
    $display("test indications done");
    // Aligned second, holdover, then loss on high uncertainty
    cyc(1); {nav_sec_edge_i, nav_fix_valid_i} <= 2'h3;
    #1 chk(nav_second_pulse_o, 0);
    cyc(1); {nav_sec_edge_i, nav_fix_valid_i} <= 2'h0;
    #1 chk(nav_second_pulse_o, 1);
    cyc(1); #1 chk(nav_second_pulse_o, 1);
    n_nv = 0;
    cyc(2 * SEC + 4); #1 chk(8'(n_nv), 2);
    cyc(1); nav_unc_high_i <= 1'b1;
    n_nv = 0;
    cyc(2 * SEC); #1 chk(8'(n_nv), 0);
    $display("test nav done");
    // Band select on, random commands and pin functions
    cyc(1); {band_sel_wr_i, band_sel_val_i} <= 2'h3;
    cyc(1); band_sel_wr_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      cmd = 13'($urandom);
      cmd.has_fourth = (i != 7);  // Last one leaves pin three alone
      cfg = 12'($urandom);
      lvl = {cmd.has_fourth ? cmd.level[3] : lvl[3], cmd.level[2:0]};
      cyc(1); antsel_valid_i <= 1'b1;
      antenna_select_command_i <= cmd;
      pin_function_config_i <= cfg;
      antenna_switch_ctrl_i <= 4'($urandom);
      cyc(1); antsel_valid_i <= 1'b0;
      cyc(2); #1 chk(antsel_band_o, cmd.band);
      chk(antenna_switch_ctrl_o, pin_exp(cfg.gpio_mode, cfg.gpio_val, lvl));
      chk(antenna_switch_ctrl_oe_o, pin_exp(cfg.gpio_mode, cfg.gpio_dir, 4'hf));
      chk(ant_gpio_in_o, antenna_switch_ctrl_i & cfg.gpio_mode);
    end
    // Restart keeps the enable; writing zero then refuses commands
    cyc(1); resetn_i <= 1'b0;
    cyc(2); resetn_i <= 1'b1;
    cyc(1); #1 chk(band_select_enable_o, 1);
    cyc(1); {band_sel_wr_i, band_sel_val_i} <= 2'h2;
    cyc(1); band_sel_wr_i <= 1'b0;
    antsel_valid_i <= 1'b1;
    antenna_select_command_i <= 13'h1fff;
    cyc(1); antsel_valid_i <= 1'b0;
    cyc(2); #1 chk(band_select_enable_o, 0);
    chk(antsel_band_o, 0);
    $display("test antenna done");
    print_verdict();
  end
endmodule // module_indication_signals_tb
